// *** dac_fmt_route.sv ***
// Serial audio input, format control, output routing and automute of a stereo DAC.
// Assumes the 3-wire control port and the audio link are asynchronous pins sampled by i_clk.
//
// Overview of operation
// - Word length from output/format bits 4:3: 16, 20, 24, 18 bits.
// - Bits 8:5 route each output: mute, left, right, or half sum.
// - Interface bit 0 selects right-justified (clear) or I2S (set) framing.
// - Interface bit 1 clear: frame clock high is left; set swaps channels.
// - Interface bits 7:6 select 44.1k, 32k or 48k group; both set reserved.
// - Each rate group covers half, base and double rates.
// - Zero-detect enable set: 1024 consecutive zero samples force output zero.
// - Mute output is off whenever enable, soft mute and mute pin are all clear.
// - Zero run counts only when both channels are zero together.
// - Zero-detect result gated by enable, then OR-ed with soft mute and the mute pin.
`timescale 1ns/10ps
module dac_fmt_route
  import dac_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire dac_pkg::pins_t i_pins,
  output dac_pkg::sample_pair_t o_audio,
  output logic o_audio_valid,
  output logic o_muted,
  output logic o_zero_latched,
  output logic [1:0] o_rate_group,
  output logic o_rate_reserved,
  output logic [8:0] o_output_format,
  output logic [8:0] o_interface_format
);
  import dac_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  pins_t meta;
  pins_t sync;
  pins_t last;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      meta <= '0;
      sync <= '0;
      last <= '0;
    end
    else
    begin
      meta <= i_pins;
      sync <= meta;
      last <= sync;
    end
  end

  logic shift_rise;
  logic latch_rise;
  logic bit_rise;
  logic frame_edge;
  assign shift_rise = sync.shift_clk & ~last.shift_clk;
  assign latch_rise = sync.latch & ~last.latch;
  assign bit_rise = sync.bit_clk & ~last.bit_clk;
  assign frame_edge = sync.frame_clk ^ last.frame_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Control port and registers
  logic [CTRL_W-1:0] ctrl_sr;
  logic [8:0] out_fmt;
  logic [8:0] if_fmt;
  logic [CTRL_W-1:0] next_ctrl_sr;
  logic [8:0] next_out_fmt;
  logic [8:0] next_if_fmt;

  always_comb
  begin
    next_ctrl_sr = ctrl_sr;
    next_out_fmt = out_fmt;
    next_if_fmt = if_fmt;
    if (shift_rise)
      next_ctrl_sr = {ctrl_sr[CTRL_W-2:0], sync.serial_in};
    if (latch_rise)
    begin
      if (ctrl_sr[ADDR_LSB+:2] == ADDR_OUTPUT_FORMAT)
        next_out_fmt = ctrl_sr[8:0];
      else if (ctrl_sr[ADDR_LSB+:2] == ADDR_INTERFACE_FORMAT)
        next_if_fmt = ctrl_sr[8:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ctrl_sr <= '0;
      out_fmt <= OUTPUT_FORMAT_RESET;
      if_fmt <= INTERFACE_FORMAT_RESET;
    end
    else
    begin
      ctrl_sr <= next_ctrl_sr;
      out_fmt <= next_out_fmt;
      if_fmt <= next_if_fmt;
    end
  end

  logic [1:0] wlen;
  logic [1:0] route_l;
  logic [1:0] route_r;
  logic i2s_mode;
  logic swap_pol;
  logic zero_en;
  logic soft_mute;
  assign wlen = out_fmt[WORD_LEN_LSB+:2];
  assign route_l = out_fmt[ROUTE_LSB+:2];
  assign route_r = out_fmt[ROUTE_LSB+2+:2];
  assign soft_mute = out_fmt[SOFT_MUTE_BIT];
  assign i2s_mode = if_fmt[FRAMING_BIT];
  assign swap_pol = if_fmt[POLARITY_BIT];
  assign zero_en = if_fmt[ZERO_DETECT_BIT];
  // Rate group for the clock dividers, each covering half, base and double rate
  assign o_rate_group = {if_fmt[RATE_LSB+1], if_fmt[RATE_LSB]};
  assign o_rate_reserved = (o_rate_group == RATE_RESERVED);
  assign o_output_format = out_fmt;
  assign o_interface_format = if_fmt;

  ////////////////////////////////////////////////////////////////////////////
  // Word helpers
  function automatic logic [4:0] word_bits(input logic [1:0] code);
    case (code)
      WLEN_16: word_bits = 5'h10;
      WLEN_20: word_bits = 5'h14;
      WLEN_24: word_bits = 5'h18;
      WLEN_18: word_bits = 5'h12;
      default: word_bits = 5'h10;
    endcase
  endfunction

  // Left-aligns the low bits of a word into the full sample width
  function automatic logic [SAMPLE_W-1:0] align(input logic [SAMPLE_W-1:0] raw, input logic [1:0] code);
    case (code)
      WLEN_16: align = {raw[15:0], 8'h00};
      WLEN_20: align = {raw[19:0], 4'h0};
      WLEN_24: align = raw;
      WLEN_18: align = {raw[17:0], 6'h00};
      default: align = raw;
    endcase
  endfunction

  function automatic logic [SAMPLE_W-1:0] pick(input logic [1:0] sel, input sample_pair_t s);
    logic [SAMPLE_W:0] sum;
    sum = {s.left[SAMPLE_W-1], s.left} + {s.right[SAMPLE_W-1], s.right};
    case (sel)
      ROUTE_MUTE: pick = '0;
      ROUTE_LEFT: pick = s.left;
      ROUTE_RIGHT: pick = s.right;
      ROUTE_MIX: pick = sum[SAMPLE_W:1];
      default: pick = '0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Serial audio receiver and output stage
  logic [SAMPLE_W-1:0] data_sr;
  logic [SAMPLE_W-1:0] i2s_word;
  logic [5:0] bit_cnt;
  sample_pair_t held;
  logic [ZERO_CNT_W-1:0] zero_cnt;
  logic zero_latched;
  logic [SAMPLE_W-1:0] next_data_sr;
  logic [SAMPLE_W-1:0] next_i2s_word;
  logic [5:0] next_bit_cnt;
  sample_pair_t next_held;
  logic [ZERO_CNT_W-1:0] next_zero_cnt;
  logic next_zero_latched;
  sample_pair_t next_audio;
  logic next_valid;
  logic [SAMPLE_W-1:0] word;
  logic is_left;
  logic pair_done;
  logic both_zero;
  logic muted;

  always_comb
  begin
    next_data_sr = data_sr;
    next_i2s_word = i2s_word;
    next_bit_cnt = bit_cnt;
    next_held = held;
    next_zero_cnt = zero_cnt;
    next_zero_latched = zero_latched;
    next_audio = o_audio;
    next_valid = 1'b0;
    // Normal format takes the last bits before the frame edge, I2S the first after the delay bit
    word = align(i2s_mode ? i2s_word : data_sr, wlen);
    is_left = last.frame_clk ^ swap_pol;
    pair_done = frame_edge & ~is_left;
    both_zero = (held.left == '0) && (word == '0);
    muted = soft_mute | sync.mute_pin | (zero_latched & zero_en);
    if (frame_edge)
    begin
      next_bit_cnt = '0;
      if (is_left)
        next_held.left = word;
      else
        next_held.right = word;
    end
    else if (bit_rise)
    begin
      next_data_sr = {data_sr[SAMPLE_W-2:0], sync.audio_data};
      if (bit_cnt != 6'h3F)
        next_bit_cnt = bit_cnt + 6'h01;
      if (bit_cnt == {1'b0, word_bits(wlen)})
        next_i2s_word = next_data_sr;
    end
    if (pair_done)
    begin
      next_valid = 1'b1;
      if (both_zero)
      begin
        if (zero_cnt != ZERO_CNT_W'(ZERO_RUN))
          next_zero_cnt = zero_cnt + 1'b1;
        if (zero_cnt == ZERO_CNT_W'(ZERO_RUN - 1))
          next_zero_latched = 1'b1;
      end
      else
      begin
        next_zero_cnt = '0;
        next_zero_latched = 1'b0;
      end
      next_held.right = word;
      next_audio.left = muted ? '0 : pick(route_l, next_held);
      next_audio.right = muted ? '0 : pick(route_r, next_held);
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      data_sr <= '0;
      i2s_word <= '0;
      bit_cnt <= '0;
      held <= '0;
      zero_cnt <= '0;
      zero_latched <= 1'b0;
      o_audio <= '0;
      o_audio_valid <= 1'b0;
      o_muted <= 1'b0;
    end
    else
    begin
      data_sr <= next_data_sr;
      i2s_word <= next_i2s_word;
      bit_cnt <= next_bit_cnt;
      held <= next_held;
      zero_cnt <= next_zero_cnt;
      zero_latched <= next_zero_latched;
      o_audio <= next_audio;
      o_audio_valid <= next_valid;
      o_muted <= muted;
    end
  end

  assign o_zero_latched = zero_latched;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_latch_out;
    latch_rise && ctrl_sr[ADDR_LSB+:2] == ADDR_OUTPUT_FORMAT;
  endsequence

  sequence s_zero_run_end;
    pair_done && both_zero && zero_cnt == ZERO_CNT_W'(ZERO_RUN - 1);
  endsequence

  a_out_reg_write: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_latch_out |=> out_fmt == $past(ctrl_sr[8:0])) else $error("output register not written");
  a_if_reg_keep: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !(latch_rise && ctrl_sr[ADDR_LSB+:2] == ADDR_INTERFACE_FORMAT) |=> if_fmt == $past(if_fmt))
    else $error("interface register changed without write");
  a_zero_latch_set: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_zero_run_end |=> zero_latched) else $error("automute not latched after zero run");
  a_zero_release: assert property (@(posedge i_clk) disable iff (!i_rstn)
    pair_done && !both_zero |=> !zero_latched && zero_cnt == '0) else $error("automute not released");
  a_one_side_zero: assert property (@(posedge i_clk) disable iff (!i_rstn)
    pair_done && (held.left != '0) |=> zero_cnt == '0) else $error("count advanced on nonzero left");
  a_auto_mute_out: assert property (@(posedge i_clk) disable iff (!i_rstn)
    pair_done && zero_latched && zero_en |=> o_audio == '0 && o_audio_valid) else $error("automute not applied");
  a_mute_off: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !zero_en && !soft_mute && !sync.mute_pin |=> !o_muted) else $error("mute with automute disabled");
  a_route_left: assert property (@(posedge i_clk) disable iff (!i_rstn)
    pair_done && !muted && route_l == ROUTE_LEFT |=> o_audio.left == $past(held.left))
    else $error("left route wrong");
  a_rate_reserved: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_rate_reserved |-> if_fmt[RATE_LSB] && if_fmt[RATE_LSB+1]) else $error("reserved flag wrong");
  a_valid_pulse: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_audio_valid |=> !o_audio_valid) else $error("valid longer than one cycle");

endmodule

// *** dac_fmt_route_tb.sv ***
// Self-checking bench of the DAC format, routing and automute block.
// Assumes dac_pkg and the source model; one 100 MHz clock.
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) \
  begin n_fail++; $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module dac_fmt_route_tb;
  import dac_pkg::*;
  logic i_clk, i_rstn, mute_pin, pol, i2s;
  pins_t src_pins, pins;
  sample_pair_t o_audio, want;
  logic o_audio_valid, o_muted, o_zero_latched, o_rate_reserved;
  logic [1:0] o_rate_group;
  logic [8:0] o_output_format, o_interface_format;
  sample_pair_t exp_q[$];
  int n_fail = 0;
  int check_count = 0;
  int wl_n[4] = '{16, 20, 24, 18};

  always_comb
  begin
    pins = src_pins;
    pins.mute_pin = mute_pin;
  end

  dac_src_model src_u (.i_clk(i_clk), .o_pins(src_pins));
  dac_fmt_route dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_pins(pins), .o_audio(o_audio),
    .o_audio_valid(o_audio_valid), .o_muted(o_muted), .o_zero_latched(o_zero_latched),
    .o_rate_group(o_rate_group), .o_rate_reserved(o_rate_reserved),
    .o_output_format(o_output_format), .o_interface_format(o_interface_format));

  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // Each new pair is held against the oldest note
  always @(posedge i_clk)
    if (o_audio_valid === 1'b1 && exp_q.size() > 0)
    begin
      want = exp_q.pop_front();
      `CHK(o_audio, want)
    end

  function automatic logic [23:0] pick(input logic [1:0] c, input logic [23:0] l, r);
    logic [24:0] s;
    s = {l[23], l} + {r[23], r};
    case (c)
      ROUTE_LEFT: return l;
      ROUTE_RIGHT: return r;
      ROUTE_MIX: return s[24:1];
      default: return 24'h000000;
    endcase
  endfunction

  task automatic pair(input logic [23:0] l, r, input int n, input logic [3:0] rt);
    sample_pair_t e;
    e.left = pick(rt[1:0], l << (24 - n), r << (24 - n));
    e.right = pick(rt[3:2], l << (24 - n), r << (24 - n));
    src_u.align(pol);
    exp_q.push_back(e);
    src_u.send_pair(l, r, n, i2s, pol);
  endtask

  task automatic final_report;
    if (n_fail == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic zero_run(input int k);
    pair(24'h000000, 24'h000000, 24, 4'h9);
    for (int j = 1; j < k; j++)
      pair(24'h000000, 24'h000000, 1, 4'h9);
    src_u.tick(10);
  endtask

  initial
  begin
    #950_000;
    n_fail++;
    final_report();
  end

  initial
  begin
    logic [1:0] c;
    logic [23:0] a, b;
    logic [8:0] of, itf;
    int n;
    i_rstn = 1'b0;
    mute_pin = 1'b0;
    pol = 1'b0;
    i2s = 1'b0;
    void'($urandom(80397));
    src_u.tick(2);
    i_rstn = 1'b1;
    `CHK(o_output_format, OUTPUT_FORMAT_RESET)
    `CHK(o_interface_format, INTERFACE_FORMAT_RESET)
    for (int i = 0; i < 8; i++)
    begin
      c = 2'(i);
      n = wl_n[c];
      i2s = i[2] ^ i[0];
      pol = i[2];
      of = {~c, c, c, 2'($urandom()), 1'b0};
      itf = {1'b0, c, 4'($urandom()), pol, i2s};
      src_u.ctrl_write(ADDR_OUTPUT_FORMAT, of);
      src_u.ctrl_write(ADDR_INTERFACE_FORMAT, itf);
      `CHK(o_output_format, of)
      `CHK(o_interface_format, itf)
      `CHK(o_rate_group, c)
      `CHK(o_rate_reserved, &c)
      a = 24'($urandom() >> (32 - n));
      b = 24'(($urandom() >> (33 - n)) << 1) | {23'h000000, a[0]};
      pair(a, b, n, of[8:5]);
      pair(b, a, n, of[8:5]);
    end
    src_u.ctrl_write(2'h0, 9'h1FF);
    `CHK(o_output_format, of)
    pol = 1'b0;
    i2s = 1'b0;
    src_u.ctrl_write(ADDR_OUTPUT_FORMAT, 9'h130);
    src_u.ctrl_write(ADDR_INTERFACE_FORMAT, 9'h000);
    mute_pin = 1'b1;
    src_u.tick(6);
    `CHK(o_muted, 1'b1)
    mute_pin = 1'b0;
    src_u.tick(6);
    `CHK(o_muted, 1'b0)
    src_u.ctrl_write(ADDR_OUTPUT_FORMAT, 9'h131);
    `CHK(o_muted, 1'b1)
    src_u.ctrl_write(ADDR_OUTPUT_FORMAT, 9'h130);
    zero_run(512);
    pair(24'h000000, 24'h000001, 24, 4'h9);
    zero_run(1023);
    `CHK(o_zero_latched, 1'b0)
    pair(24'h000000, 24'h000000, 1, 4'h9);
    src_u.tick(10);
    `CHK(o_zero_latched, 1'b1)
    `CHK(o_muted, 1'b0)
    src_u.ctrl_write(ADDR_INTERFACE_FORMAT, 9'h100);
    `CHK(o_muted, 1'b1)
    // The releasing pair itself still leaves muted
    exp_q.push_back('0);
    src_u.send_pair(24'h000100, 24'h000000, 24, 1'b0, 1'b0);
    src_u.tick(10);
    `CHK(o_zero_latched, 1'b0)
    `CHK(o_muted, 1'b0)
    `CHK(exp_q.size(), 0)
    // Reset in mid-run brings the registers back
    i_rstn = 1'b0;
    src_u.tick(2);
    `CHK(o_interface_format, INTERFACE_FORMAT_RESET)
    `CHK(o_output_format, OUTPUT_FORMAT_RESET)
    i_rstn = 1'b1;
    src_u.tick(6);
    `CHK(o_muted, 1'b0)
    final_report();
  end
endmodule

// *** dac_pkg.sv ***
// Shared constants and types of the DAC input format, routing and automute block.
// Assumes one system clock; all pins are asynchronous to it.
package dac_pkg;

  localparam int SAMPLE_W = 24;
  localparam int CTRL_W = 16;

  // Control word layout
  localparam int ADDR_LSB = 9;
  localparam logic [1:0] ADDR_OUTPUT_FORMAT = 2'h2;
  localparam logic [1:0] ADDR_INTERFACE_FORMAT = 2'h3;

  // Output/format register fields
  localparam int SOFT_MUTE_BIT = 0;
  localparam int WORD_LEN_LSB = 3;
  localparam int ROUTE_LSB = 5;
  localparam logic [8:0] OUTPUT_FORMAT_RESET = 9'h120;

  // Interface register fields
  localparam int FRAMING_BIT = 0;
  localparam int POLARITY_BIT = 1;
  localparam int RATE_LSB = 6;
  localparam int ZERO_DETECT_BIT = 8;
  localparam logic [8:0] INTERFACE_FORMAT_RESET = 9'h000;

  // Word length codes
  localparam logic [1:0] WLEN_16 = 2'h0;
  localparam logic [1:0] WLEN_20 = 2'h1;
  localparam logic [1:0] WLEN_24 = 2'h2;
  localparam logic [1:0] WLEN_18 = 2'h3;

  // Route codes per output
  localparam logic [1:0] ROUTE_MUTE = 2'h0;
  localparam logic [1:0] ROUTE_LEFT = 2'h1;
  localparam logic [1:0] ROUTE_RIGHT = 2'h2;
  localparam logic [1:0] ROUTE_MIX = 2'h3;

  // Rate group codes {bit7, bit6}
  localparam logic [1:0] RATE_44K1 = 2'h0;
  localparam logic [1:0] RATE_32K = 2'h1;
  localparam logic [1:0] RATE_48K = 2'h2;
  localparam logic [1:0] RATE_RESERVED = 2'h3;

  localparam int ZERO_RUN = 1024;
  localparam int ZERO_CNT_W = 11;

  typedef struct packed {
    logic [SAMPLE_W-1:0] left;
    logic [SAMPLE_W-1:0] right;
  } sample_pair_t;

  typedef struct packed {
    logic latch;
    logic shift_clk;
    logic serial_in;
    logic frame_clk;
    logic bit_clk;
    logic audio_data;
    logic mute_pin;
  } pins_t;

endpackage

// *** dac_src_model.sv ***
// Audio source and control-port master model facing the DAC format block.
// Assumes the caller's i_clk; every pin change lands 1 ns after a rising edge.
`timescale 1ns/10ps
module dac_src_model
(
  input wire logic i_clk,
  output dac_pkg::pins_t o_pins
);
  import dac_pkg::*;

  initial o_pins = '0;

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Control word: 16 bits MSB first, then a latch pulse
  task automatic ctrl_write(input logic [1:0] addr, input logic [8:0] data);
    logic [15:0] w;
    w = {5'h00, addr, data};
    for (int b = 15; b >= 0; b--)
    begin
      o_pins.serial_in = w[b];
      tick(4);
      o_pins.shift_clk = 1'b1;
      tick(4);
      o_pins.shift_clk = 1'b0;
    end
    tick(4);
    o_pins.latch = 1'b1;
    tick(4);
    o_pins.latch = 1'b0;
    tick(6);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Audio link: 160 ns bit clock, still outside frames
  task automatic bit_out(input logic d);
    o_pins.audio_data = d;
    tick(8);
    o_pins.bit_clk = 1'b1;
    tick(8);
    o_pins.bit_clk = 1'b0;
  endtask

  // One half: optional delay slot, then n bits MSB first
  task automatic half(input logic [23:0] v, input int n, input logic dly);
    if (dly)
      bit_out(~v[n-1]);
    for (int b = n - 1; b >= 0; b--)
      bit_out(v[b]);
    o_pins.audio_data = ~o_pins.audio_data;
  endtask

  // Frame clock rests at the left level between pairs
  task automatic align(input logic pol);
    if (o_pins.frame_clk !== ~pol)
    begin
      o_pins.frame_clk = ~pol;
      tick(16);
    end
  endtask

  task automatic send_pair(input logic [23:0] l, r, input int n, input logic i2s, pol);
    half(l, n, i2s);
    o_pins.frame_clk = pol;
    tick(4);
    half(r, n, i2s);
    o_pins.frame_clk = ~pol;
    tick(4);
  endtask
endmodule
